// ===== hw/gml_pkg.sv
// package of register map, field layout and carrier types for the memory layout bank
package gml_pkg;
  // register offsets, byte addresses with bit 0 ignored by the word decode
  localparam logic [10:0] OFF_DISP_WIDTH = 11'h010;
  localparam logic [10:0] OFF_DISP_HEIGHT = 11'h012;
  localparam logic [10:0] OFF_FRAME_ZERO = 11'h014;
  localparam logic [10:0] OFF_FRAME_ONE = 11'h016;
  localparam logic [10:0] OFF_LIST_HIGH = 11'h018;
  localparam logic [10:0] OFF_LIST_LOW = 11'h01a;
  localparam logic [10:0] OFF_SOURCE = 11'h01c;
  localparam logic [10:0] OFF_WORK = 11'h01e;
  localparam logic [10:0] OFF_CTRL = 11'h020;
  localparam logic [10:0] OFF_STATUS = 11'h022;
  // field masks of defined bits
  localparam logic [15:0] MASK_WIDTH = 16'h03ff;
  localparam logic [15:0] MASK_HEIGHT = 16'h01ff;
  localparam logic [15:0] MASK_BASE7 = 16'h007f;
  localparam logic [15:0] MASK_LIST_LOW = 16'hffe0;
  localparam logic [15:0] MASK_AREA = 16'he07f;
  localparam logic [15:0] MASK_CTRL = 16'h0003;
  localparam logic [15:0] MASK_STATUS = 16'h0001;
  // control field positions
  localparam int CTRL_SHOW_BIT = 0;
  localparam int CTRL_SELECT_BIT = 1;
  // reset values of the control register (layout fields keep their value)
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;
  // bus answer timing: one wait cycle on every access
  localparam int WAIT_CYCLES = 1;

  typedef enum logic [1:0] {
    GML_IDLE = 2'b00,
    GML_ACK = 2'b01
  } gml_bus_state_type;

  typedef struct packed {
    logic [6:0] display_base;
    logic [6:0] render_base;
    logic render_from_frame;
    logic [17:0] list_base;
    logic [9:0] area_base_source;
    logic [9:0] area_base_work;
    logic [9:0] screen_width_dots;
    logic [8:0] screen_height_dots;
  } gml_layout_type;
endpackage : gml_pkg

// ===== hw/gml_field_reg.sv
// one 16-bit register holding only its defined bits, no reset
`timescale 1ns/1ps
module gml_field_reg #(
  parameter logic [15:0] MASK = 16'hffff
) (
  input wire logic core_clk,
  input wire logic wr_en,
  input wire logic [15:0] wr_data,
  output logic [15:0] value
);
  logic [15:0] value_r;
  // keeps contents through reset; undefined bits never stored
  always_ff @(posedge core_clk) begin
    if (wr_en) begin
      value_r <= wr_data & MASK;
    end
  end
  assign value = value_r;
endmodule : gml_field_reg

// ===== hw/gml_shadow.sv
// shadow copy that loads the live value on an update strobe
`timescale 1ns/1ps
module gml_shadow (
  input wire logic core_clk,
  input wire logic load,
  input wire logic [6:0] live,
  output logic [6:0] held
);
  logic [6:0] held_r;
  // takes effect only at the update strobe
  always_ff @(posedge core_clk) begin
    if (load) begin
      held_r <= live;
    end
  end
  assign held = held_r;
endmodule : gml_shadow

// ===== hw/graphics_memory_layout_regs.sv
// memory layout register bank with avalon-mm slave and effective address outputs
//
// Design decision made here: the Avalon-MM slave port.
`timescale 1ns/1ps
module graphics_memory_layout_regs (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic [10:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic internal_update,
  input wire logic external_update,
  output gml_pkg::gml_layout_type layout
);
  ////////////////////////////////////////////////////////////////////////////
  // bus handshake
  gml_pkg::gml_bus_state_type state_r;
  logic req;
  logic take;
  assign req = avs_read | avs_write;
  assign take = (state_r == gml_pkg::GML_ACK);

  // one wait cycle, then answer with waitrequest low
  always_ff @(posedge core_clk) begin
    if (srst) begin
      state_r <= gml_pkg::GML_IDLE;
    end else begin
      case (state_r)
        gml_pkg::GML_IDLE: begin
          if (req) begin
            state_r <= gml_pkg::GML_ACK;
          end
        end
        gml_pkg::GML_ACK: begin
          state_r <= gml_pkg::GML_IDLE;
        end
        default: begin
          state_r <= gml_pkg::GML_IDLE;
        end
      endcase
    end
  end

  logic waitreq_r;
  // waitrequest low only in the answer cycle
  always_ff @(posedge core_clk) begin
    if (srst) begin
      waitreq_r <= 1'b1;
    end else begin
      waitreq_r <= !(state_r == gml_pkg::GML_IDLE && req);
    end
  end
  assign avs_waitrequest = waitreq_r;

  ////////////////////////////////////////////////////////////////////////////
  // write decode
  function automatic logic hit(input logic [10:0] a, input logic [10:0] off);
    hit = ({a[10:1], 1'b0} == off);
  endfunction : hit

  logic lane_ok;
  logic wr;
  logic [15:0] wd;
  assign lane_ok = &avs_byteenable[1:0];
  assign wr = take & avs_write & lane_ok;
  assign wd = avs_writedata[15:0];

  logic [15:0] v_width, v_height, v_frame0, v_frame1, v_lh, v_ll, v_src, v_wrk;

  // per-register write enables, full low half-word only
  logic we_width;
  logic we_height;
  logic we_frame0;
  logic we_frame1;
  logic we_list_high;
  logic we_list_low;
  logic we_source;
  logic we_work;
  logic we_ctrl;
  assign we_width = wr & hit(avs_address, gml_pkg::OFF_DISP_WIDTH);
  assign we_height = wr & hit(avs_address, gml_pkg::OFF_DISP_HEIGHT);
  assign we_frame0 = wr & hit(avs_address, gml_pkg::OFF_FRAME_ZERO);
  assign we_frame1 = wr & hit(avs_address, gml_pkg::OFF_FRAME_ONE);
  assign we_list_high = wr & hit(avs_address, gml_pkg::OFF_LIST_HIGH);
  assign we_list_low = wr & hit(avs_address, gml_pkg::OFF_LIST_LOW);
  assign we_source = wr & hit(avs_address, gml_pkg::OFF_SOURCE);
  assign we_work = wr & hit(avs_address, gml_pkg::OFF_WORK);
  assign we_ctrl = wr & hit(avs_address, gml_pkg::OFF_CTRL);

  // origin of an area register: address bits 22..16 then 15..13
  function automatic logic [9:0] area_origin(input logic [15:0] r);
    area_origin = {r[6:0], r[15:13]};
  endfunction : area_origin

  gml_field_reg #(.MASK(gml_pkg::MASK_WIDTH)) u_width (
    .core_clk(core_clk),
    .wr_en(we_width),
    .wr_data(wd),
    .value(v_width)
  );
  gml_field_reg #(.MASK(gml_pkg::MASK_HEIGHT)) u_height (
    .core_clk(core_clk),
    .wr_en(we_height),
    .wr_data(wd),
    .value(v_height)
  );
  gml_field_reg #(.MASK(gml_pkg::MASK_BASE7)) u_frame0 (
    .core_clk(core_clk),
    .wr_en(we_frame0),
    .wr_data(wd),
    .value(v_frame0)
  );
  gml_field_reg #(.MASK(gml_pkg::MASK_BASE7)) u_frame1 (
    .core_clk(core_clk),
    .wr_en(we_frame1),
    .wr_data(wd),
    .value(v_frame1)
  );
  gml_field_reg #(.MASK(gml_pkg::MASK_BASE7)) u_lh (
    .core_clk(core_clk),
    .wr_en(we_list_high),
    .wr_data(wd),
    .value(v_lh)
  );
  gml_field_reg #(.MASK(gml_pkg::MASK_LIST_LOW)) u_ll (
    .core_clk(core_clk),
    .wr_en(we_list_low),
    .wr_data(wd),
    .value(v_ll)
  );
  gml_field_reg #(.MASK(gml_pkg::MASK_AREA)) u_src (
    .core_clk(core_clk),
    .wr_en(we_source),
    .wr_data(wd),
    .value(v_src)
  );
  gml_field_reg #(.MASK(gml_pkg::MASK_AREA)) u_wrk (
    .core_clk(core_clk),
    .wr_en(we_work),
    .wr_data(wd),
    .value(v_wrk)
  );

  ////////////////////////////////////////////////////////////////////////////
  // control: displayed buffer flag and render address select
  logic displayed_buffer_flag_r;
  logic render_address_select_r;
  logic displayed_buffer_flag_nxt;
  logic render_address_select_nxt;

  // next control bits: written value on a control write, else held
  always_comb begin
    displayed_buffer_flag_nxt = displayed_buffer_flag_r;
    render_address_select_nxt = render_address_select_r;
    if (we_ctrl) begin
      displayed_buffer_flag_nxt = wd[gml_pkg::CTRL_SHOW_BIT];
      render_address_select_nxt = wd[gml_pkg::CTRL_SELECT_BIT];
    end
  end

  // control bits reset to defined values
  always_ff @(posedge core_clk) begin
    if (srst) begin
      displayed_buffer_flag_r <= gml_pkg::CTRL_RESET[gml_pkg::CTRL_SHOW_BIT];
      render_address_select_r <= gml_pkg::CTRL_RESET[gml_pkg::CTRL_SELECT_BIT];
    end else begin
      displayed_buffer_flag_r <= displayed_buffer_flag_nxt;
      render_address_select_r <= render_address_select_nxt;
    end
  end

  // shown flag follows control flag at internal update
  logic shown_flag_r;
  always_ff @(posedge core_clk) begin
    if (srst) begin
      shown_flag_r <= 1'b0;
    end else if (internal_update) begin
      shown_flag_r <= displayed_buffer_flag_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // effective frame bases
  logic [6:0] disp_live, rend_live, disp_held, rend_held;
  assign disp_live = displayed_buffer_flag_r ? v_frame1[6:0] : v_frame0[6:0];
  assign rend_live = displayed_buffer_flag_r ? v_frame0[6:0] : v_frame1[6:0];

  gml_shadow u_disp (
    .core_clk(core_clk),
    .load(internal_update),
    .live(disp_live),
    .held(disp_held)
  );
  gml_shadow u_rend (
    .core_clk(core_clk),
    .load(external_update),
    .live(rend_live),
    .held(rend_held)
  );

  // registered layout output, one flop group per field
  logic [6:0] display_base_r;
  logic [6:0] render_base_r;
  logic render_from_frame_r;
  logic [17:0] list_base_r;
  logic [9:0] source_base_r;
  logic [9:0] work_base_r;
  logic [9:0] width_dots_r;
  logic [8:0] height_dots_r;

  // shown frame base, moves only after an internal update
  always_ff @(posedge core_clk) begin
    if (srst) begin
      display_base_r <= 7'h00;
    end else begin
      display_base_r <= disp_held;
    end
  end

  // render origin base, moves only after an external update
  always_ff @(posedge core_clk) begin
    if (srst) begin
      render_base_r <= 7'h00;
    end else begin
      render_base_r <= rend_held;
    end
  end

  // origin taken from the hidden frame while select is low
  always_ff @(posedge core_clk) begin
    if (srst) begin
      render_from_frame_r <= 1'b0;
    end else begin
      render_from_frame_r <= ~render_address_select_r;
    end
  end

  // display list base, high and low halves joined
  always_ff @(posedge core_clk) begin
    if (srst) begin
      list_base_r <= 18'h00000;
    end else begin
      list_base_r <= {v_lh[6:0], v_ll[15:5]};
    end
  end

  // source area origin
  always_ff @(posedge core_clk) begin
    if (srst) begin
      source_base_r <= 10'h000;
    end else begin
      source_base_r <= area_origin(v_src);
    end
  end

  // work area origin
  always_ff @(posedge core_clk) begin
    if (srst) begin
      work_base_r <= 10'h000;
    end else begin
      work_base_r <= area_origin(v_wrk);
    end
  end

  // screen width in dots
  always_ff @(posedge core_clk) begin
    if (srst) begin
      width_dots_r <= 10'h000;
    end else begin
      width_dots_r <= v_width[9:0];
    end
  end

  // screen height in dots
  always_ff @(posedge core_clk) begin
    if (srst) begin
      height_dots_r <= 9'h000;
    end else begin
      height_dots_r <= v_height[8:0];
    end
  end

  // output carrier assembled from the field flops
  assign layout = '{
    display_base: display_base_r,
    render_base: render_base_r,
    render_from_frame: render_from_frame_r,
    list_base: list_base_r,
    area_base_source: source_base_r,
    area_base_work: work_base_r,
    screen_width_dots: width_dots_r,
    screen_height_dots: height_dots_r
  };

  ////////////////////////////////////////////////////////////////////////////
  // read back
  logic [15:0] rd_mux;
  always_comb begin
    rd_mux = 16'h0000;
    case ({avs_address[10:1], 1'b0})
      gml_pkg::OFF_DISP_WIDTH: rd_mux = v_width;
      gml_pkg::OFF_DISP_HEIGHT: rd_mux = v_height;
      gml_pkg::OFF_FRAME_ZERO: rd_mux = v_frame0;
      gml_pkg::OFF_FRAME_ONE: rd_mux = v_frame1;
      gml_pkg::OFF_LIST_HIGH: rd_mux = v_lh;
      gml_pkg::OFF_LIST_LOW: rd_mux = v_ll;
      gml_pkg::OFF_SOURCE: rd_mux = v_src;
      gml_pkg::OFF_WORK: rd_mux = v_wrk;
      gml_pkg::OFF_CTRL: rd_mux = {14'h0000, render_address_select_r, displayed_buffer_flag_r};
      gml_pkg::OFF_STATUS: rd_mux = {15'h0000, shown_flag_r};
      default: rd_mux = gml_pkg::UNMAPPED_DATA[15:0];
    endcase
  end

  logic [31:0] rdata_r;
  // read data captured while waiting, stands at the answer edge
  always_ff @(posedge core_clk) begin
    if (srst) begin
      rdata_r <= 32'h0000_0000;
    end else if (state_r == gml_pkg::GML_IDLE && avs_read) begin
      rdata_r <= {16'h0000, rd_mux};
    end
  end
  assign avs_readdata = rdata_r;
endmodule : graphics_memory_layout_regs

// ===== verification/gml_chk.sv
// checker of bus answer timing and layout outputs of the memory layout bank
`timescale 1ns/1ps
module gml_chk (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic [10:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic internal_update,
  input wire logic external_update,
  input wire gml_pkg::gml_layout_type layout
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  logic armed_r = 1'b0;
  logic [9:0] wa;
  logic [15:0] wd;
  logic wok;
  // word address, low write data and a full low half-word write answer
  assign wa = avs_address[10:1];
  assign wd = avs_writedata[15:0];
  assign wok = avs_write && !avs_waitrequest && avs_byteenable[1:0] == 2'b11;
  // display base is defined once an update was seen
  always_ff @(posedge core_clk) begin
    if (internal_update) armed_r <= 1'b1;
  end
  property p_ans; $rose(avs_read || avs_write) |-> avs_waitrequest ##1 !avs_waitrequest;
    endproperty
  a_ans: assert property (p_ans) else $error("late answer");
  property p_unm; avs_read && !avs_waitrequest && (wa < 10'h008 || wa > 10'h011)
    |-> avs_readdata == 32'h0; endproperty
  a_unm: assert property (p_unm) else $error("unmapped read data");
  property p_wid; wok && wa == 10'h008
    |-> ##2 layout.screen_width_dots == $past(wd[9:0], 2); endproperty
  a_wid: assert property (p_wid) else $error("width field");
  property p_hgt; wok && wa == 10'h009
    |-> ##2 layout.screen_height_dots == $past(wd[8:0], 2); endproperty
  a_hgt: assert property (p_hgt) else $error("height field");
  property p_lst; wok && wa == 10'h00c
    |-> ##2 layout.list_base[17:11] == $past(wd[6:0], 2); endproperty
  a_lst: assert property (p_lst) else $error("list base");
  property p_lsl; wok && wa == 10'h00d
    |-> ##2 layout.list_base[10:0] == $past(wd[15:5], 2); endproperty
  a_lsl: assert property (p_lsl) else $error("list base low");
  property p_src; wok && wa == 10'h00e
    |-> ##2 layout.area_base_source == $past({wd[6:0], wd[15:13]}, 2); endproperty
  a_src: assert property (p_src) else $error("source base");
  property p_wrk; wok && wa == 10'h00f
    |-> ##2 layout.area_base_work == $past({wd[6:0], wd[15:13]}, 2); endproperty
  a_wrk: assert property (p_wrk) else $error("work base");
  property p_dsp; $past(armed_r, 2) && !$past(internal_update, 2) && !$past(srst)
    && !$past(srst, 2) |-> $stable(layout.display_base); endproperty
  a_dsp: assert property (p_dsp) else $error("display base moved");
endmodule : gml_chk
bind graphics_memory_layout_regs gml_chk u_chk (.core_clk(core_clk), .srst(srst),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .internal_update(internal_update),
  .external_update(external_update), .layout(layout));

// ===== verification/tb.sv
// self-checking bench of the memory layout register bank
`timescale 1ns/1ps
module tb;
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic iu = 1'b0;
  logic eu = 1'b0;
  logic [10:0] adr = 11'h000;
  logic [31:0] wdat = 32'h0;
  logic [3:0] be = 4'hf;
  logic [31:0] rdat;
  logic wreq;
  gml_pkg::gml_layout_type lay;
  logic [15:0] exp_q[$];
  logic [15:0] v[8];
  logic [15:0] nv;
  int n_fail = 0;
  int comparisons = 0;
  int cyc = 0;
  localparam logic [15:0] MSK[8] = '{16'h03ff, 16'h01ff, 16'h007f, 16'h007f, 16'h007f,
    16'hffe0, 16'he07f, 16'he07f};
  graphics_memory_layout_regs uut (.core_clk(core_clk), .srst(srst), .avs_address(adr),
    .avs_read(rd), .avs_write(wr), .avs_writedata(wdat), .avs_byteenable(be),
    .avs_readdata(rdat), .avs_waitrequest(wreq), .internal_update(iu),
    .external_update(eu), .layout(lay));
  initial begin
    forever #2 core_clk = ~core_clk;
  end
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : give_verdict
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : cmp
  // one transfer, held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [10:0] a, input logic [15:0] d);
    @(posedge core_clk);
    adr <= a;
    rd <= !w;
    wr <= w;
    wdat <= {16'h0000, d};
    do @(posedge core_clk); while (wreq !== 1'b0);
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : bus
  task automatic rdx(input logic [10:0] a, input logic [15:0] e);
    exp_q.push_back(e);
    bus(1'b0, a, 16'h0000);
  endtask : rdx
  task automatic settle();
    repeat (2) @(negedge core_clk);
  endtask : settle
  // one update pulse, internal or external
  task automatic upd(input logic ext);
    @(posedge core_clk);
    iu <= !ext;
    eu <= ext;
    @(posedge core_clk);
    iu <= 1'b0;
    eu <= 1'b0;
    settle();
  endtask : upd
  // read answers against the oldest note, and the run limit
  always @(posedge core_clk) begin
    cyc++;
    if (rd && wreq === 1'b0) cmp(rdat, {16'h0000, exp_q.pop_front()});
    if (cyc == 20000) begin
      n_fail++;
      give_verdict();
    end
  end
  // main sequence
  initial begin
    void'($urandom(23038));
    repeat (20) @(posedge core_clk);
    srst <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      v[i] = 16'($urandom) & MSK[i];
      bus(1'b1, 11'h010 + 11'(2 * i), v[i]);
    end
    be <= 4'h1;
    bus(1'b1, 11'h010, ~v[0] & MSK[0]);
    be <= 4'hf;
    bus(1'b1, 11'h030, 16'h0055);
    for (int i = 0; i < 8; i++) rdx(11'h010 + 11'(2 * i), v[i]);
    rdx(11'h030, 16'h0000);
    rdx(11'h00e, 16'h0000);
    settle();
    cmp({lay.screen_width_dots, lay.screen_height_dots}, {v[0][9:0], v[1][8:0]});
    cmp(lay.list_base, {v[4][6:0], v[5][15:5]});
    cmp({lay.area_base_source, lay.area_base_work},
      {v[6][6:0], v[6][15:13], v[7][6:0], v[7][15:13]});
    // mid-run reset keeps the layout fields
    @(posedge core_clk);
    srst <= 1'b1;
    repeat (3) @(posedge core_clk);
    srst <= 1'b0;
    for (int i = 0; i < 8; i++) rdx(11'h010 + 11'(2 * i), v[i]);
    bus(1'b1, 11'h020, 16'h0000);
    upd(1'b0);
    upd(1'b1);
    cmp({lay.display_base, lay.render_base, lay.render_from_frame},
      {v[2][6:0], v[3][6:0], 1'b1});
    nv = ~v[2] & 16'h007f;
    bus(1'b1, 11'h014, nv);
    settle();
    cmp(lay.display_base, v[2][6:0]);
    upd(1'b0);
    cmp(lay.display_base, nv[6:0]);
    bus(1'b1, 11'h020, 16'h0001);
    upd(1'b0);
    upd(1'b0);
    upd(1'b1);
    cmp({lay.display_base, lay.render_base}, {v[3][6:0], nv[6:0]});
    rdx(11'h022, 16'h0001);
    bus(1'b1, 11'h020, 16'h0003);
    settle();
    cmp(lay.render_from_frame, 1'b0);
    give_verdict();
  end
endmodule : tb
